// [hw/ftbsr_core.sv]
/*
  Flow-through burst SRAM core: synchronous control, burst counter, byte lanes.
  Assumes a memory controller on the far side and a testbench that resolves
  the shared data pins from the output enables.
*/
module ftbsr_core #(
  parameter int ADDR_W = ftbsr_pkg::DEF_ADDR_W,
  parameter int LANES = ftbsr_pkg::DEF_LANES
) (
  input wire logic clock_in, // 40 MHz clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic clock_gate_n_in, // Low qualifies the edge
  input wire logic chip_select_first_n_in, // Chip select, active low
  input wire logic chip_select_second_in, // Chip select, active high
  input wire logic chip_select_third_n_in, // Chip select, active low
  input wire logic advance_load_in, // High advances, low loads
  input wire logic write_select_n_in, // Low selects write
  input wire logic [LANES-1:0] byte_lane_write_n_in, // Per-lane write, active low
  input wire logic output_enable_n_in, // Asynchronous output enable
  input wire logic sleep_request_in, // Asynchronous sleep request
  input wire logic burst_mode_in, // Strap: high interleaved
  input wire logic [ADDR_W-1:0] addr_in, // Address, low two bits burst
  input wire logic [LANES*8-1:0] data_in, // Data pins, input side
  input wire logic [LANES-1:0] parity_lines_in, // Parity pins, input side
  output logic [LANES*8-1:0] data_out, // Data pins, output side
  output logic [LANES-1:0] parity_lines_out, // Parity pins, output side
  output logic data_oe_out, // High while data and parity driven
  output logic sleeping_out // High while in low-power state
);
  localparam int LW = ftbsr_pkg::LANE_DATA_W + 1;
  localparam int DEPTH = 1 << ADDR_W;

  logic [LANES*LW-1:0] mem [DEPTH];

  ftbsr_pkg::ftbsr_op_type op_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [1:0] step_reg;
  logic [1:0] low_addr;
  logic [ADDR_W-1:0] cur_addr;
  logic first_reg;
  logic [1:0] sleep_cnt_reg;
  logic asleep_reg;
  logic edge_ok;
  logic selected;
  logic [LANES*LW-1:0] rd_word;
  logic [LANES*LW-1:0] wr_word;

  function automatic logic all_selected(input logic c1n, input logic c2, input logic c3n);
    all_selected = !c1n && c2 && !c3n;
  endfunction

  assign selected = all_selected(chip_select_first_n_in, chip_select_second_in,
    chip_select_third_n_in);
  // gated edge ignored; sleep drops pending edges
  assign edge_ok = !clock_gate_n_in && !asleep_reg && !sleep_request_in;

  ftbsr_burst_step u_step (
    .start_in(base_reg[1:0]),
    .step_in(step_reg),
    .interleaved_in(burst_mode_in),
    .addr_out(low_addr)
  );
  assign cur_addr = {base_reg[ADDR_W-1:2], low_addr};

  // load on selects and load; advance ignores selects; no wait states
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      op_reg <= ftbsr_pkg::FTBSR_IDLE;
      base_reg <= '0;
      step_reg <= '0;
      first_reg <= 1'b0;
    end
    else if (edge_ok)
    begin
      if (!advance_load_in)
      begin
        first_reg <= (op_reg == ftbsr_pkg::FTBSR_IDLE);
        if (selected)
        begin
          base_reg <= addr_in;
          step_reg <= '0;
          op_reg <= write_select_n_in ? ftbsr_pkg::FTBSR_READ : ftbsr_pkg::FTBSR_WRITE;
        end
        else
          op_reg <= ftbsr_pkg::FTBSR_IDLE;
      end
      else if (op_reg != ftbsr_pkg::FTBSR_IDLE)
      begin
        step_reg <= 2'(step_reg + 2'h1);
        first_reg <= 1'b0;
      end
    end
  end

  // Write data of the current beat arrives at the next qualified edge
  always_comb
  begin
    wr_word = mem[cur_addr];
    for (int i = 0; i < LANES; i++)
      if (!byte_lane_write_n_in[i])
        wr_word[i*LW +: LW] = {parity_lines_in[i], data_in[i*8 +: 8]};
  end

  always_ff @(posedge clock_in)
  begin
    if (!srst_in && edge_ok && op_reg == ftbsr_pkg::FTBSR_WRITE)
      mem[cur_addr] <= wr_word;
  end

  assign rd_word = mem[cur_addr];
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      data_out[i*8 +: 8] = rd_word[i*LW +: 8];
      parity_lines_out[i] = rd_word[i*LW + 8];
    end
  end

  // output enable gates drive; writes never drive; first clock floats
  assign data_oe_out = (op_reg == ftbsr_pkg::FTBSR_READ) && !output_enable_n_in &&
    !first_reg && !asleep_reg && !sleep_request_in;

  // two cycles to enter or leave sleep
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      sleep_cnt_reg <= '0;
      asleep_reg <= 1'b0;
    end
    else if (sleep_request_in != asleep_reg)
    begin
      if (sleep_cnt_reg == 2'(ftbsr_pkg::SLEEP_ENTRY_CYC - 1))
      begin
        asleep_reg <= sleep_request_in;
        sleep_cnt_reg <= '0;
      end
      else
        sleep_cnt_reg <= 2'(sleep_cnt_reg + 2'h1);
    end
    else
      sleep_cnt_reg <= '0;
  end
  assign sleeping_out = asleep_reg;

  // Building blocks for the protocol checks
  sequence s_load;
    edge_ok && selected && !advance_load_in;
  endsequence

  sequence s_read_load;
    edge_ok && selected && !advance_load_in && write_select_n_in;
  endsequence

  sequence s_write_load;
    edge_ok && selected && !advance_load_in && !write_select_n_in;
  endsequence

  sequence s_advance;
    edge_ok && advance_load_in && op_reg != ftbsr_pkg::FTBSR_IDLE;
  endsequence

  // Reads reach the pins only with the enable low and no sleep
  sequence s_oe_open;
    !output_enable_n_in && !sleep_request_in;
  endsequence

  a_gate_holds: assert property (@(posedge clock_in) disable iff (srst_in)
    clock_gate_n_in |=> $stable(op_reg) && $stable(step_reg))
    else $error("state changed on gated edge");

  a_gate_hold_addr: assert property (@(posedge clock_in) disable iff (srst_in)
    clock_gate_n_in |=> $stable(base_reg) && $stable(first_reg))
    else $error("address or first flag changed on gated edge");

  a_load_read: assert property (@(posedge clock_in) disable iff (srst_in)
    s_read_load |=> op_reg == ftbsr_pkg::FTBSR_READ && step_reg == 2'h0)
    else $error("read not started");

  a_load_write: assert property (@(posedge clock_in) disable iff (srst_in)
    s_write_load |=> op_reg == ftbsr_pkg::FTBSR_WRITE && step_reg == 2'h0 && !data_oe_out)
    else $error("write not started");

  a_load_addr: assert property (@(posedge clock_in) disable iff (srst_in)
    s_load |=> base_reg == $past(addr_in))
    else $error("address not captured at load");

  // Back to back read loads: the second one drives in its own cycle
  a_read_flow: assert property (@(posedge clock_in) disable iff (srst_in)
    (op_reg != ftbsr_pkg::FTBSR_IDLE) ##0 s_read_load ##1 s_oe_open |-> data_oe_out)
    else $error("read data not driven");

  a_deselect_float: assert property (@(posedge clock_in) disable iff (srst_in)
    edge_ok && !selected && !advance_load_in |=> !data_oe_out)
    else $error("outputs driven after deselect");

  a_deselect_idle: assert property (@(posedge clock_in) disable iff (srst_in)
    edge_ok && !selected && !advance_load_in |=> op_reg == ftbsr_pkg::FTBSR_IDLE)
    else $error("deselect did not end the access");

  a_oe_gates: assert property (@(posedge clock_in) disable iff (srst_in)
    output_enable_n_in |-> !data_oe_out)
    else $error("driving with output enable high");

  a_write_float: assert property (@(posedge clock_in) disable iff (srst_in)
    op_reg == ftbsr_pkg::FTBSR_WRITE |-> !data_oe_out)
    else $error("driving during write");

  a_burst_count: assert property (@(posedge clock_in) disable iff (srst_in)
    s_advance |=> step_reg == 2'($past(step_reg) + 2'h1))
    else $error("burst counter not advanced");

  a_burst_wrap: assert property (@(posedge clock_in) disable iff (srst_in)
    s_advance ##0 (step_reg == 2'h3) |=> step_reg == 2'h0)
    else $error("burst counter did not wrap");

  a_order_interleaved: assert property (@(posedge clock_in) disable iff (srst_in)
    burst_mode_in |-> low_addr == (base_reg[1:0] ^ step_reg))
    else $error("interleaved burst address wrong");

  a_order_linear: assert property (@(posedge clock_in) disable iff (srst_in)
    !burst_mode_in |-> low_addr == 2'(base_reg[1:0] + step_reg))
    else $error("linear burst address wrong");

  a_adv_keeps_addr: assert property (@(posedge clock_in) disable iff (srst_in)
    s_advance |=> $stable(base_reg))
    else $error("advance reloaded the address");

  a_dir_held: assert property (@(posedge clock_in) disable iff (srst_in)
    advance_load_in && op_reg != ftbsr_pkg::FTBSR_IDLE |=> $stable(op_reg))
    else $error("direction changed mid burst");

  a_write_beat: assert property (@(posedge clock_in) disable iff (srst_in)
    s_write_load ##1 s_advance |=> op_reg == ftbsr_pkg::FTBSR_WRITE && step_reg == 2'h1)
    else $error("write burst did not step");

  a_idle_stays: assert property (@(posedge clock_in) disable iff (srst_in)
    advance_load_in && op_reg == ftbsr_pkg::FTBSR_IDLE |=> op_reg == ftbsr_pkg::FTBSR_IDLE)
    else $error("advance left deselect");

  a_first_float: assert property (@(posedge clock_in) disable iff (srst_in)
    edge_ok && !advance_load_in && op_reg == ftbsr_pkg::FTBSR_IDLE |=> !data_oe_out)
    else $error("drove on first clock after deselect");

  a_sleep_enter: assert property (@(posedge clock_in) disable iff (srst_in)
    (!asleep_reg && sleep_request_in) [*2] |=> asleep_reg)
    else $error("sleep not entered in two cycles");

  a_sleep_exit: assert property (@(posedge clock_in) disable iff (srst_in)
    (asleep_reg && !sleep_request_in) [*2] |=> !asleep_reg)
    else $error("sleep not left in two cycles");

  a_sleep_float: assert property (@(posedge clock_in) disable iff (srst_in)
    sleep_request_in || asleep_reg |-> !data_oe_out)
    else $error("driving while asleep");

  // A pending beat is dropped rather than half done
  a_sleep_blocks: assert property (@(posedge clock_in) disable iff (srst_in)
    sleep_request_in |=> $stable(op_reg) && $stable(base_reg) && $stable(step_reg))
    else $error("state moved during sleep request");

  // Not disabled by reset: it checks what reset leaves behind
  a_reset_idle: assert property (@(posedge clock_in)
    srst_in |=> op_reg == ftbsr_pkg::FTBSR_IDLE && !data_oe_out && !sleeping_out)
    else $error("reset did not leave the core deselected");

  // selected lane takes data and parity
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane_chk
    a_lane_taken: assert property (@(posedge clock_in) disable iff (srst_in)
      op_reg == ftbsr_pkg::FTBSR_WRITE && !byte_lane_write_n_in[g]
      |-> wr_word[g*LW +: LW] == {parity_lines_in[g], data_in[g*8 +: 8]})
      else $error("selected lane not taken");
  end
endmodule

// [hw/ftbsr_pkg.sv]
/*
  Package for the flow-through burst SRAM core: widths, encodings, timing.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package ftbsr_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  // Clock to data valid, in picoseconds
  localparam int CLOCK_TO_DATA_VALID_PS = 7500;
  localparam int CLOCK_TO_DATA_VALID_CYC =
    (CLOCK_TO_DATA_VALID_PS / CLK_PERIOD_PS) < 1 ? 1 : (CLOCK_TO_DATA_VALID_PS / CLK_PERIOD_PS);
  // Sleep entry and recovery, in clock cycles
  localparam int SLEEP_ENTRY_CYC = 2;
  localparam int SLEEP_RECOVERY_TIME_CYC = 2;
  localparam int SLEEP_CNT_W = 2;
  localparam int BURST_W = 2;
  localparam int LANE_DATA_W = 8;
  localparam int DEF_LANES = 4;
  localparam int DEF_ADDR_W = 8;

  typedef enum logic [1:0] {
    FTBSR_IDLE = 2'b00,
    FTBSR_READ = 2'b01,
    FTBSR_WRITE = 2'b10
  } ftbsr_op_type;
endpackage

// [hw/ftbsr_burst_step.sv]
/*
  Burst address step: current low address bits for linear or interleaved order.
  Assumes the caller holds the start bits and the step count.
*/
module ftbsr_burst_step (
  input wire logic [1:0] start_in, // Low address bits at burst load
  input wire logic [1:0] step_in, // Beats already taken, modulo four
  input wire logic interleaved_in, // High selects interleaved order
  output logic [1:0] addr_out // Low address bits for this beat
);
  always_comb
  begin
    if (interleaved_in)
      addr_out = start_in ^ step_in;
    else
      addr_out = 2'(start_in + step_in);
  end
endmodule

// [bench/ftbsr_ctrl_model.sv]
/*
  Memory controller model for the burst SRAM core.
  Assumes the bench calls its tasks and resolves the shared data lines.
*/
module ftbsr_ctrl_model (
  input wire logic clock_in, // 40 MHz clock
  output logic gate_n_out, // Clock gate, low qualifies
  output logic [2:0] sel_out, // first_n, second, third_n
  output logic adv_out, // High advances burst
  output logic we_n_out, // Low writes at load
  output logic [3:0] bw_n_out, // Lane writes, active low
  output logic oe_n_out, // Output enable, active low
  output logic sleep_out, // Sleep request
  output logic [7:0] addr_out, // Address
  output logic [35:0] wd_out, // Parity then data
  output logic wd_oe_out // High while driving data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    gate_n_out = 1'b0;
    sel_out = 3'b101;
    adv_out = 1'b0;
    we_n_out = 1'b1;
    bw_n_out = 4'hf;
    oe_n_out = 1'b0;
    sleep_out = 1'b0;
    addr_out = 8'h00;
    wd_out = 36'h0;
    wd_oe_out = 1'b0;
  end
  task automatic beat(input logic [2:0] s, input logic a, input logic w,
    input logic [3:0] b, input logic [7:0] ad, input logic de, input logic [35:0] d);
    @(negedge clock_in);
    gate_n_out = 1'b0;
    sel_out = s;
    adv_out = a;
    we_n_out = w;
    bw_n_out = b;
    addr_out = ad;
    wd_oe_out = de;
    wd_out = de ? d : ~wd_out;
    @(posedge clock_in);
    #1;
  endtask
  task automatic stall();
    @(negedge clock_in);
    gate_n_out = 1'b1;
    adv_out = 1'b1;
    // Gate stays high until the next beat reopens it on a falling edge
    @(posedge clock_in);
    #1;
  endtask
  task automatic set_oe(input logic v);
    @(negedge clock_in);
    oe_n_out = v;
    #1;
  endtask
  task automatic set_sleep(input logic v);
    @(negedge clock_in);
    sleep_out = v;
  endtask
endmodule

// [bench/tb_flow_through_burst_sram_core.sv]
/*
  Testbench for the burst SRAM core: bursts, byte lanes, gating, sleep.
  Assumes the controller model and default core parameters.
*/
module tb_flow_through_burst_sram_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, srst_in, mode, gate_n, adv, we_n, oe_n, slp, wd_oe;
  logic data_oe_out, sleeping_out;
  logic [2:0] sel;
  logic [3:0] bw_n, parity_lines_out;
  logic [7:0] addr;
  logic [31:0] data_out;
  logic [35:0] wd, bus;
  logic [35:0] exp_mem [4];
  int n_errors = 0;
  int check_count = 0;
  assign bus = (data_oe_out && !wd_oe) ? {parity_lines_out, data_out} : wd;
  ftbsr_ctrl_model m_ctl (.clock_in(clock_in), .gate_n_out(gate_n), .sel_out(sel),
    .adv_out(adv), .we_n_out(we_n), .bw_n_out(bw_n), .oe_n_out(oe_n), .sleep_out(slp),
    .addr_out(addr), .wd_out(wd), .wd_oe_out(wd_oe));
  ftbsr_core dut (.clock_in(clock_in), .srst_in(srst_in), .clock_gate_n_in(gate_n),
    .chip_select_first_n_in(sel[2]), .chip_select_second_in(sel[1]),
    .chip_select_third_n_in(sel[0]), .advance_load_in(adv), .write_select_n_in(we_n),
    .byte_lane_write_n_in(bw_n), .output_enable_n_in(oe_n), .sleep_request_in(slp),
    .burst_mode_in(mode), .addr_in(addr), .data_in(bus[31:0]),
    .parity_lines_in(bus[35:32]), .data_out(data_out),
    .parity_lines_out(parity_lines_out), .data_oe_out(data_oe_out),
    .sleeping_out(sleeping_out));
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  function automatic logic [1:0] nx(input logic m, input logic [1:0] s, input logic [1:0] k);
    return m ? (s ^ k) : (s + k);
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_burst(input logic m, input logic [1:0] st, input logic [35:0] base);
    int k;
    @(negedge clock_in);
    mode = m;
    m_ctl.beat(3'b010, 1'b0, 1'b0, 4'hf, {6'h08, st}, 1'b0, 36'h0);
    check("oe at write", 36'(data_oe_out), 36'h0);
    // Selects, direction and address junk on advance beats must be ignored
    for (k = 0; k < 4; k++)
    begin
      exp_mem[nx(m, st, 2'(k))] = base + 36'(k) * 36'h1_0101_0101;
      m_ctl.beat(3'b101, k != 3, 1'b1, 4'h0, 8'hff, 1'b1, exp_mem[nx(m, st, 2'(k))]);
      check("oe write beat", 36'(data_oe_out), 36'h0);
    end
  endtask
  task automatic rd_burst(input logic m, input logic [1:0] st);
    int k;
    @(negedge clock_in);
    mode = m;
    m_ctl.beat(3'b010, 1'b0, 1'b1, 4'hf, {6'h08, st}, 1'b0, 36'h0);
    check("oe first read", 36'(data_oe_out), 36'h0);
    m_ctl.beat(3'b010, 1'b0, 1'b1, 4'h0, {6'h08, st}, 1'b0, 36'h0);
    for (k = 0; k < 5; k++)
    begin
      check("read word", {parity_lines_out, data_out}, exp_mem[nx(m, st, 2'(k))]);
      check("oe read", 36'(data_oe_out), 36'h1);
      if (k == 1)
      begin
        m_ctl.stall();
        check("stalled word", {parity_lines_out, data_out}, exp_mem[nx(m, st, 2'(k))]);
      end
      if (k < 4)
        m_ctl.beat(3'b101, 1'b1, 1'b0, 4'h0, 8'h00, 1'b0, 36'h0);
    end
    m_ctl.set_oe(1'b1);
    check("oe masked", 36'(data_oe_out), 36'h0);
    // The single edge crossed here is a dummy read that advances the open burst
    m_ctl.set_oe(1'b0);
    check("oe reopened", 36'(data_oe_out), 36'h1);
    m_ctl.beat(3'b101, 1'b0, 1'b1, 4'hf, 8'h00, 1'b0, 36'h0);
    check("oe deselect", 36'(data_oe_out), 36'h0);
    m_ctl.beat(3'b101, 1'b1, 1'b0, 4'hf, 8'h00, 1'b0, 36'h0);
    check("oe stay deselected", 36'(data_oe_out), 36'h0);
  endtask
  task automatic lanes();
    m_ctl.beat(3'b010, 1'b0, 1'b0, 4'hf, 8'h20, 1'b0, 36'h0);
    m_ctl.beat(3'b101, 1'b0, 1'b1, 4'b1010, 8'h00, 1'b1, 36'h5_5555_5555);
    // Lanes 0 and 2 with their parity bits
    exp_mem[0] = (exp_mem[0] & 36'ha_ff00_ff00) | 36'h5_0055_0055;
    rd_burst(1'b0, 2'b00);
  endtask
  task automatic wait_sleep(input logic v);
    int i;
    for (i = 0; i < 8 && sleeping_out !== v; i++)
    begin
      @(posedge clock_in);
      #1;
    end
    check("sleeping", 36'(sleeping_out), 36'(v));
    check("sleep cycles", 36'(i), 36'(ftbsr_pkg::SLEEP_ENTRY_CYC));
    if (sleeping_out !== v)
      end_of_test();
  endtask
  task automatic sleep_test();
    m_ctl.set_sleep(1'b1);
    wait_sleep(1'b1);
    check("oe asleep", 36'(data_oe_out), 36'h0);
    m_ctl.set_sleep(1'b0);
    wait_sleep(1'b0);
    repeat (2) m_ctl.beat(3'b101, 1'b0, 1'b1, 4'hf, 8'h00, 1'b0, 36'h0);
    rd_burst(1'b1, 2'b11);
  endtask
  initial
  begin
    srst_in = 1'b1;
    mode = 1'b0;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    srst_in = 1'b0;
    check("oe reset", 36'(data_oe_out), 36'h0);
    check("sleep reset", 36'(sleeping_out), 36'h0);
    wr_burst(1'b0, 2'b01, 36'h1_1234_5678);
    rd_burst(1'b1, 2'b01);
    wr_burst(1'b1, 2'b10, 36'h8_8765_4321);
    rd_burst(1'b0, 2'b10);
    lanes();
    sleep_test();
    end_of_test();
  end
endmodule
